// *** hdl/flash_status_pkg.sv ***
`default_nettype none
package flash_status_pkg;
   // Command codes driven on the data bus
   localparam logic [15:0] CMD_CLEAR_STATUS = 16'h0050;
   localparam logic [15:0] CMD_READ_STATUS = 16'h0070;
   localparam logic [15:0] CMD_RESUME = 16'h00D0;
   localparam logic [7:0] STATUS_RESET_VALUE = 8'h80;
   localparam logic [15:0] UPPER_ZERO_MASK = 16'hFF00;
   // Status bit positions
   localparam int READY_BIT = 7;
   localparam int ERASE_SUSP_BIT = 6;
   localparam int ERASE_FAIL_BIT = 5;
   localparam int PROG_FAIL_BIT = 4;
   localparam int SUPPLY_BIT = 3;
   localparam int PROG_SUSP_BIT = 2;
   localparam int LOCKED_BIT = 1;
   localparam int RESERVED_BIT = 0;
   // Controller register map (word offsets on the local port)
   localparam logic [1:0] REG_CTRL = 2'h0;
   localparam logic [1:0] REG_STATUS = 2'h1;
   localparam logic [1:0] REG_INFO = 2'h2;
   // Control register bits
   localparam int CTRL_CLEAR_BIT = 0;
   localparam int CTRL_POLL_BIT = 1;
   localparam int CTRL_SELECT_BIT = 2;
   localparam int CTRL_RESUME_BIT = 3;
   // Pin timing: 50 MHz clock
   localparam int CLK_PERIOD_NS = 20;
   localparam int PULSE_NS = 80;
   localparam int PULSE_CYC = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] PULSE_CYC_W = 4'(PULSE_CYC);

   // Pin group towards the flash device
   typedef struct packed {
      logic chip_enable_n;
      logic output_enable_n;
      logic write_enable_n;
      logic [15:0] data_out;
      logic data_oe;
   } flash_pins_s;

   typedef enum logic [5:0] {
      ST_IDLE = 6'b000001,
      ST_WR_SETUP = 6'b000010,
      ST_WR_PULSE = 6'b000100,
      ST_RD_PULSE = 6'b001000,
      ST_RD_GAP = 6'b010000,
      ST_DONE = 6'b100000
   } seq_state_e;
endpackage
`default_nettype wire

// *** hdl/pulse_timer.sv ***
`default_nettype none
// Down-counter that flags expiry of a pin phase
module pulse_timer
   import flash_status_pkg::*;
#(
   parameter int WIDTH = 4
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic load_i,
   input wire logic [WIDTH-1:0] count_i,
   output logic done_o
);
   initial begin
      if (WIDTH < 2) $error("pulse_timer WIDTH too small");
   end

   typedef struct packed {
      logic [WIDTH-1:0] cnt;
      logic done;
   } timer_s;
   timer_s q_r, q_nxt;

   // Load, then count to zero; done is registered
   always_comb begin
      q_nxt = q_r;
      if (load_i) begin
         q_nxt.cnt = count_i;
         q_nxt.done = 1'b0;
      end else if (q_r.cnt != '0) begin
         q_nxt.cnt = q_r.cnt - 1'b1;
         q_nxt.done = (q_r.cnt == WIDTH'(1));
      end else begin
         q_nxt.done = 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q_r <= '0;
      end else if (ce_i) begin
         q_r <= q_nxt;
      end
   end
   assign done_o = q_r.done;
endmodule // pulse_timer
`default_nettype wire

// *** hdl/flash_status_host.sv ***
// The implementer's own choices: strobed register access and the register addresses.
`default_nettype none
// Contract
// - Error flags stick until host issues clear-status.
// - Host uses no page bursts in status mode; separate accesses.
// - Host raises output enable or deselects between status reads.
// - Clear-status is one write of 0050h, any address.
// - Host clears status before resuming a suspended erase; the controller sends clear first only when clear and resume are both queued.
module flash_status_host
   import flash_status_pkg::*;
#(
   parameter int PULSE_CYCLES = PULSE_CYC
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // Local register port
   input wire logic [1:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   // Flash pins
   output logic chip_enable_n_o,
   output logic output_enable_n_o,
   output logic write_enable_n_o,
   output logic [15:0] data_o,
   output logic data_oe_o,
   input wire logic [15:0] data_i
);
   initial begin
      if (PULSE_CYCLES < 1 || PULSE_CYCLES > 15) $error("PULSE_CYCLES out of range");
   end

   typedef struct packed {
      seq_state_e state;
      flash_pins_s pins;
      logic is_read;
      logic [15:0] cmd;
      logic pend_clear;
      logic pend_poll;
      logic pend_resume;
      logic status_mode;
      logic [7:0] status;
      logic valid;
      logic proto_err;
      logic [31:0] rdata;
   } host_s;
   host_s q_r, q_nxt;

   logic timer_load;
   logic timer_done;

   pulse_timer #(.WIDTH(4)) u_timer (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .load_i(timer_load),
      .count_i(4'(PULSE_CYCLES)),
      .done_o(timer_done)
   );

   // Bit 7 decides whether the rest of the byte is meaningful
   function automatic logic [7:0] accept_status(input logic [7:0] raw);
      if (!raw[READY_BIT]) accept_status = 8'h00;
      else accept_status = {raw[7:1], 1'b0};
   endfunction

   // Sequencer: issues single-cycle writes and separate status reads
   always_comb begin
      q_nxt = q_r;
      timer_load = 1'b0;
      q_nxt.rdata = q_r.rdata;
      if (rd_i) begin
         case (addr_i)
            REG_CTRL: q_nxt.rdata = {28'h0, q_r.pend_resume, 1'b0, q_r.pend_poll,
                                     q_r.pend_clear};
            REG_STATUS: q_nxt.rdata = {22'h0, q_r.proto_err, q_r.valid, q_r.status};
            REG_INFO: q_nxt.rdata = {30'h0, q_r.status_mode, q_r.state == ST_IDLE};
            default: q_nxt.rdata = 32'h0;
         endcase
      end
      case (q_r.state)
         ST_IDLE: begin
            // Clear precedes a queued resume, so old errors do not mask new ones
            if (q_r.pend_clear) begin
               q_nxt.cmd = CMD_CLEAR_STATUS;
               q_nxt.pend_clear = 1'b0;
               q_nxt.is_read = 1'b0;
               q_nxt.state = ST_WR_SETUP;
            end else if (q_r.pend_poll && !q_r.status_mode) begin
               q_nxt.cmd = CMD_READ_STATUS;
               q_nxt.is_read = 1'b0;
               q_nxt.state = ST_WR_SETUP;
            end else if (q_r.pend_poll) begin
               q_nxt.pend_poll = 1'b0;
               q_nxt.is_read = 1'b1;
               q_nxt.pins.chip_enable_n = 1'b0;
               q_nxt.pins.output_enable_n = 1'b0;
               q_nxt.pins.data_oe = 1'b0;
               timer_load = 1'b1;
               q_nxt.state = ST_RD_PULSE;
            end else if (q_r.pend_resume) begin
               q_nxt.cmd = CMD_RESUME;
               q_nxt.pend_resume = 1'b0;
               q_nxt.is_read = 1'b0;
               q_nxt.state = ST_WR_SETUP;
            end
         end
         ST_WR_SETUP: begin
            q_nxt.pins.chip_enable_n = 1'b0;
            q_nxt.pins.write_enable_n = 1'b0;
            q_nxt.pins.data_out = q_r.cmd;
            q_nxt.pins.data_oe = 1'b1;
            timer_load = 1'b1;
            q_nxt.state = ST_WR_PULSE;
         end
         ST_WR_PULSE: begin
            // Rising write enable latches the command; no confirm cycle follows
            if (timer_done) begin
               q_nxt.pins.write_enable_n = 1'b1;
               q_nxt.pins.chip_enable_n = 1'b1;
               // Clear and status-read both leave the device in status mode
               q_nxt.status_mode = (q_r.cmd != CMD_RESUME);
               if (q_r.cmd == CMD_CLEAR_STATUS) q_nxt.status = STATUS_RESET_VALUE & 8'h00;
               q_nxt.state = ST_DONE;
            end
         end
         ST_RD_PULSE: begin
            if (timer_done) begin
               // Upper lines must be zero in status mode
               q_nxt.proto_err = q_r.proto_err | ((data_i & UPPER_ZERO_MASK) != 16'h0000);
               q_nxt.status = accept_status(data_i[7:0]);
               q_nxt.valid = data_i[READY_BIT];
               // Raise OE and deselect so the next read relatches
               q_nxt.pins.output_enable_n = 1'b1;
               q_nxt.pins.chip_enable_n = 1'b1;
               timer_load = 1'b1;
               q_nxt.state = ST_RD_GAP;
            end
         end
         ST_RD_GAP: begin
            if (timer_done) q_nxt.state = ST_DONE;
         end
         ST_DONE: begin
            q_nxt.pins.data_oe = 1'b0;
            q_nxt.state = ST_IDLE;
         end
         default: q_nxt.state = ST_IDLE;
      endcase
      // Register writes queue requests; the controller writes the byte itself only on a clear, to 00h.
      // Applied after the sequencer so a new request is not lost when an old one is taken.
      if (wr_i && addr_i == REG_CTRL) begin
         if (wdata_i[CTRL_CLEAR_BIT]) q_nxt.pend_clear = 1'b1;
         if (wdata_i[CTRL_POLL_BIT]) q_nxt.pend_poll = 1'b1;
         if (wdata_i[CTRL_RESUME_BIT]) q_nxt.pend_resume = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q_r <= '0;
         q_r.state <= ST_IDLE;
         q_r.pins.chip_enable_n <= 1'b1;
         q_r.pins.output_enable_n <= 1'b1;
         q_r.pins.write_enable_n <= 1'b1;
         q_r.status <= STATUS_RESET_VALUE;
      end else if (ce_i) begin
         q_r <= q_nxt;
      end
   end

   assign rdata_o = q_r.rdata;
   assign chip_enable_n_o = q_r.pins.chip_enable_n;
   assign output_enable_n_o = q_r.pins.output_enable_n;
   assign write_enable_n_o = q_r.pins.write_enable_n;
   assign data_o = q_r.pins.data_out;
   assign data_oe_o = q_r.pins.data_oe;

   // Never write and read enables low together
   a_no_contention: assert property (@(posedge clk_i) disable iff (rst_i)
      !(!write_enable_n_o && !output_enable_n_o)) else $error("WE and OE both low");
   sequence s_read_end;
      $rose(output_enable_n_o);
   endsequence
   a_read_deselect: assert property (@(posedge clk_i) disable iff (rst_i)
      s_read_end |-> chip_enable_n_o) else $error("read not ended by deselect");
   a_clear_code: assert property (@(posedge clk_i) disable iff (rst_i)
      $fell(write_enable_n_o) && q_r.cmd == CMD_CLEAR_STATUS |-> data_o == 16'h0050
      && data_oe_o) else $error("clear code wrong");
   a_busy_zeroed: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && q_r.state == ST_RD_PULSE && timer_done && !data_i[7] |=> q_r.status == 8'h00)
      else $error("busy byte not ignored");
   a_reserved_zero: assert property (@(posedge clk_i) disable iff (rst_i)
      q_r.status[RESERVED_BIT] == 1'b0) else $error("reserved bit set");
   a_clear_first: assert property (@(posedge clk_i) disable iff (rst_i)
      q_r.state == ST_IDLE && q_r.pend_clear && q_r.pend_resume && ce_i |=> q_r.cmd
      == CMD_CLEAR_STATUS) else $error("resume before clear");
   a_clear_kept: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && wr_i && addr_i == REG_CTRL && wdata_i[CTRL_CLEAR_BIT] |=> q_r.pend_clear)
      else $error("clear request lost");
   a_status_mode: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && q_r.state == ST_WR_PULSE && timer_done && q_r.cmd == CMD_READ_STATUS
      |=> q_r.status_mode) else $error("status mode not taken");
   a_reset_value: assert property (@(posedge clk_i)
      $past(rst_i) |-> q_r.status == 8'h80) else $error("reset value wrong");
endmodule // flash_status_host
`default_nettype wire

// *** dv/flash_dev_model.sv ***
`default_nettype none
// Behavioural flash device: status byte, read mode and command decode
module flash_dev_model
   import flash_status_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_n_i,
   input wire logic oe_n_i,
   input wire logic we_n_i,
   input wire logic [15:0] host_d_i,
   input wire logic busy_i,
   input wire logic [7:0] inj_i,
   input wire logic inj_v_i,
   input wire logic [6:0] junk_i,
   output logic [15:0] dq_o
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [15:0] ARRAY_WORD = 16'h3CA5;
   logic [7:0] byte_r;
   logic [7:0] latch_r;
   logic stat_r;
   logic ce_q, oe_q, we_q;
   logic [15:0] d_q, last_r;
   // Pins sampled on the clock so both edges of a write are seen in order
   always_ff @(posedge clk_i) begin
      ce_q <= ce_n_i;
      oe_q <= oe_n_i;
      we_q <= we_n_i;
      d_q <= host_d_i;
      if (!ce_n_i && !oe_n_i) last_r <= dq_o;
      if (rst_i) begin
         byte_r <= STATUS_RESET_VALUE;
         stat_r <= 1'b0;
      end else begin
         if (inj_v_i) byte_r <= byte_r | inj_i;
         // No supply check on any command here, so lockout never blocks them
         if (we_n_i && !we_q && !ce_q) begin
            if (d_q == CMD_CLEAR_STATUS) begin
               byte_r <= byte_r & 8'hC5;
               stat_r <= 1'b1;
            end
            if (d_q == CMD_READ_STATUS) stat_r <= 1'b1;
            if (d_q == CMD_RESUME) begin
               byte_r <= byte_r & 8'hBB;
               stat_r <= 1'b1;
            end
         end
      end
      // Latch only on the selecting edge; a held strobe keeps the old byte
      if (!ce_n_i && !oe_n_i && (oe_q || ce_q))
         latch_r <= busy_i ? {1'b0, junk_i} : {1'b1, byte_r[6:1], 1'b0};
   end
   // A released bus shows the inverse of its last value, never a stale copy
   always_comb begin
      if (!ce_n_i && !oe_n_i) dq_o = stat_r ? {8'h00, latch_r} : ARRAY_WORD;
      else dq_o = ~last_r;
   end
endmodule // flash_dev_model
`default_nettype wire

// *** dv/flash_status_host_tb_top.sv ***
`default_nettype none
module flash_status_host_tb_top;
   import flash_status_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i, rst_i, wr_i, rd_i, ce_n, oe_n, we_n, d_oe, busy, inj_v;
   logic [1:0] addr_i;
   logic [31:0] wdata_i, rdata_o, s, lfsr;
   logic [15:0] d_o, dq, data_i;
   logic [7:0] inj, exp_byte;
   logic [6:0] junk;
   logic [7:0] codes [7] = '{8'h10, 8'h20, 8'h30, 8'h08, 8'h02, 8'h40, 8'h04};
   int err_count, comparisons, cyc;
   assign data_i = d_oe ? d_o : dq;
   flash_status_host DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .chip_enable_n_o(ce_n), .output_enable_n_o(oe_n), .write_enable_n_o(we_n),
      .data_o(d_o), .data_oe_o(d_oe), .data_i(data_i));
   flash_dev_model dev (.clk_i(clk_i), .rst_i(rst_i), .ce_n_i(ce_n), .oe_n_i(oe_n),
      .we_n_i(we_n), .host_d_i(d_o), .busy_i(busy), .inj_i(inj), .inj_v_i(inj_v),
      .junk_i(junk), .dq_o(dq));
   always #10 clk_i = ~clk_i;
   function automatic logic [31:0] lfsr_next(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task automatic wr(input logic [1:0] a, input logic [31:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask
   // Read data stand from the cycle after the strobe until the next read strobe
   task automatic rd(input logic [1:0] a, output logic [31:0] d);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 d = rdata_o;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("Error %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   // Issue a control bit, then wait until nothing is pending and the sequencer idles
   task automatic cmd(input int b);
      logic [31:0] c, i;
      int n;
      wr(REG_CTRL, 32'h1 << b);
      for (n = 0; n < 300; n++) begin
         rd(REG_CTRL, c);
         rd(REG_INFO, i);
         if (c[3:0] === 4'h0 && i[0] === 1'b1) break;
      end
      if (n == 300) check(32'h0, 32'h1, "command stuck");
      if (b == CTRL_CLEAR_BIT) exp_byte &= 8'hC5;
      if (b == CTRL_RESUME_BIT) exp_byte &= 8'hBB;
   endtask
   // Busy reads keep a zero byte and no ready mark
   task automatic poll();
      cmd(CTRL_POLL_BIT);
      rd(REG_STATUS, s);
      check(s, busy ? 32'h0 : {22'h0, 2'b01, exp_byte}, "status");
   endtask
   task automatic inject(input logic [7:0] m);
      @(posedge clk_i);
      inj <= m;
      inj_v <= 1'b1;
      @(posedge clk_i);
      inj_v <= 1'b0;
      exp_byte |= m;
   endtask
   task automatic results();
      $display("comparisons %0d err_count %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // A hang is cut short well beyond the expected run length
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         err_count++;
         $display("Error %0t: timeout", $time);
         results();
      end
   end
   initial begin
      clk_i = 0; rst_i = 1; wr_i = 0; rd_i = 0; addr_i = 2'h0; wdata_i = 32'h0;
      busy = 0; inj = 8'h00; inj_v = 0; junk = 7'h00; cyc = 0;
      err_count = 0; comparisons = 0; lfsr = 32'hC04D; exp_byte = 8'h80;
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      poll();
      $display("test reset default done");
      foreach (codes[k]) begin
         inject(codes[k]);
         poll();
         poll();
         cmd((codes[k] & 8'h44) != 0 ? CTRL_RESUME_BIT : CTRL_CLEAR_BIT);
         poll();
      end
      $display("test flag codes done");
      inject(8'h40);
      inject(8'h30);
      poll();
      cmd(CTRL_CLEAR_BIT);
      cmd(CTRL_RESUME_BIT);
      poll();
      $display("test suspend sequence error done");
      busy <= 1'b1;
      repeat (4) begin
         lfsr = lfsr_next(lfsr);
         junk <= lfsr[6:0];
         poll();
      end
      busy <= 1'b0;
      poll();
      $display("test busy done");
      repeat (6) begin
         lfsr = lfsr_next(lfsr);
         inject(lfsr[7:0] & 8'h3A);
         poll();
      end
      cmd(CTRL_CLEAR_BIT);
      rd(REG_INFO, s);
      check(s, 32'h3, "info mode");
      poll();
      $display("test random errors done");
      rd(2'h3, s);
      check(s, 32'h0, "unmapped");
      $display("test unmapped done");
      results();
   end
endmodule // flash_status_host_tb_top
`default_nettype wire
